// ===== core/xpd_pkg.sv
/*
 * Shared constants, types and decode helpers for the transceiver
 * power-down and receive register bank.
 * Assumes a serial host port front end that delivers one register
 * access at a time on the core clock, and analog blocks that act on
 * the power, recalibration and configuration-load controls.
 */
// Behaviour
// - Register 3 bit 0 sleeps receive path
// - Register 131 bit 0 sleeps transmit path
// - Registers reachable while one path powered
// - Sleeping-path writes apply after wake and recalibration
// - Bit 3 of 8/136 starts full recalibration
// - Sleeping-path register reads are undefined
// - SPI-like port: any access wakes both-asleep device
// - Wake only the most recently slept path
// - Two-wire port: accesses never wake device
// - Supply return: both paths up, auto recalibrate
// - Select pin high picks SPI-like port
// - Alarms sampled at 10 MHz into sticky status
package xpd_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_ID_LOW      = 8'h00;
    localparam logic [7:0] ADDR_ID_REV      = 8'h01;
    localparam logic [7:0] ADDR_CHIP_CFG    = 8'h02;
    localparam logic [7:0] ADDR_RX_POWER    = 8'h03;
    localparam logic [7:0] ADDR_RX_INT_MASK = 8'h04;
    localparam logic [7:0] ADDR_RX_INT_STAT = 8'h05;
    localparam logic [7:0] ADDR_RX_MULT     = 8'h06;
    localparam logic [7:0] ADDR_RX_LOCK     = 8'h07;
    localparam logic [7:0] ADDR_RX_CAL      = 8'h08;
    localparam logic [7:0] ADDR_RX_ALARM    = 8'h09;
    localparam logic [7:0] ADDR_RX_LOSS_CTL = 8'h0a;
    localparam logic [7:0] ADDR_RX_LOSS_ST  = 8'h0b;
    localparam logic [7:0] ADDR_AMP_THR     = 8'h0c;
    localparam logic [7:0] ADDR_AMP_HYST    = 8'h0d;
    localparam logic [7:0] ADDR_PEAK_LOW    = 8'h0f;
    localparam logic [7:0] ADDR_PEAK_HIGH   = 8'h10;
    localparam logic [7:0] ADDR_DLOSS_SET   = 8'h11;
    localparam logic [7:0] ADDR_DLOSS_CLR   = 8'h12;
    localparam logic [7:0] ADDR_SLICE_CFG   = 8'h14;
    localparam logic [7:0] ADDR_SLICE_LOW   = 8'h15;
    localparam logic [7:0] ADDR_SLICE_HIGH  = 8'h16;
    localparam logic [7:0] ADDR_PHASE_ADJ   = 8'h18;
    localparam logic [7:0] ADDR_SQM_VALUE   = 8'h19;
    localparam logic [7:0] ADDR_SQM_THR     = 8'h1a;
    localparam logic [7:0] ADDR_SQM_CLR     = 8'h1b;
    localparam logic [7:0] ADDR_DPATH_CFG   = 8'h1c;
    localparam logic [7:0] ADDR_TP_SEL      = 8'h1d;
    localparam logic [7:0] ADDR_TX_POWER    = 8'h83;
    localparam logic [7:0] ADDR_TX_CAL      = 8'h88;

    // Reset values
    localparam logic [7:0] RST_CHIP_CFG   = 8'h58;
    localparam logic [7:0] RST_RX_MULT    = 8'h40;
    localparam logic [7:0] RST_RX_LOCK    = 8'h15;
    localparam logic [7:0] RST_RX_LOSS    = 8'h01;
    localparam logic [7:0] RST_AMP_THR    = 8'h0f;
    localparam logic [7:0] RST_AMP_HYST   = 8'h70;
    localparam logic [7:0] RST_DLOSS_SET  = 8'h05;
    localparam logic [7:0] RST_DLOSS_CLR  = 8'h60;
    localparam logic [7:0] RST_SLICE_CFG  = 8'h11;
    localparam logic [7:0] RST_SQM_THR    = 8'h29;
    localparam logic [7:0] RST_SQM_CLR    = 8'h0f;
    localparam logic [7:0] RST_DPATH_CFG  = 8'h02;
    localparam logic [7:0] RST_TX_POWER   = 8'h22;
    localparam logic [7:0] RST_TX_CAL     = 8'h00;
    localparam logic [7:0] RST_ZERO       = 8'h00;

    // Field positions
    localparam int BIT_SLEEP      = 0;
    localparam int BIT_FULL_RECAL = 3;
    localparam int BIT_GLOBAL_IE  = 5;

    // Alarm sampling tick: 10 MHz from the core clock, cycle count rounded down to 12
    localparam longint CLK_HZ       = 125_000_000;
    localparam longint SAMPLE_HZ    = 10_000_000;
    localparam int     TICK_CYCLES  = int'(CLK_HZ / SAMPLE_HZ);
    localparam int     TICK_W       = 4;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    localparam int MEM_AW = 5;
    localparam logic [MEM_AW-1:0] MEM_LAST = 5'h1f;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } xpd_acc_t;

    typedef struct packed {
        logic [6:0] alarm;
        logic [7:0] loss;
        logic [9:0] peak;
        logic [5:0] sqm;
    } xpd_live_t;

    typedef struct packed {
        logic rx_sleep;
        logic tx_sleep;
        logic rx_recal;
        logic tx_recal;
        logic rx_load;
    } xpd_ctl_t;

    // Plain read/write bytes kept in the memory
    function automatic logic is_mem_reg(input logic [7:0] a);
        case (a)
            ADDR_RX_MULT, ADDR_RX_LOCK, ADDR_RX_LOSS_CTL, ADDR_AMP_THR,
            ADDR_AMP_HYST, ADDR_DLOSS_SET, ADDR_DLOSS_CLR, ADDR_SLICE_CFG,
            ADDR_SLICE_LOW, ADDR_SLICE_HIGH, ADDR_PHASE_ADJ, ADDR_SQM_THR,
            ADDR_SQM_CLR, ADDR_DPATH_CFG, ADDR_TP_SEL: is_mem_reg = 1'b1;
            default: is_mem_reg = 1'b0;
        endcase
    endfunction : is_mem_reg

    function automatic logic [7:0] mem_default(input logic [MEM_AW-1:0] a);
        case ({3'b000, a})
            ADDR_RX_MULT:     mem_default = RST_RX_MULT;
            ADDR_RX_LOCK:     mem_default = RST_RX_LOCK;
            ADDR_RX_LOSS_CTL: mem_default = RST_RX_LOSS;
            ADDR_AMP_THR:     mem_default = RST_AMP_THR;
            ADDR_AMP_HYST:    mem_default = RST_AMP_HYST;
            ADDR_DLOSS_SET:   mem_default = RST_DLOSS_SET;
            ADDR_DLOSS_CLR:   mem_default = RST_DLOSS_CLR;
            ADDR_SLICE_CFG:   mem_default = RST_SLICE_CFG;
            ADDR_SQM_THR:     mem_default = RST_SQM_THR;
            ADDR_SQM_CLR:     mem_default = RST_SQM_CLR;
            ADDR_DPATH_CFG:   mem_default = RST_DPATH_CFG;
            default:          mem_default = RST_ZERO;
        endcase
    endfunction : mem_default

endpackage : xpd_pkg

// ===== core/xpd_sync.sv
/*
 * Two-stage synchroniser for a bundle of asynchronous levels.
 * Assumes the inputs are slow levels; wide values may be caught torn
 * for one cycle.
 */
`timescale 1ns/1ps
module xpd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clock,
    input  wire logic             i_sys_rst,
    input  wire logic             i_clk_en,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } xpd_sync_st_t;

    xpd_sync_st_t st_r;
    xpd_sync_st_t st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.meta = i_async;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            st_r <= '0;
        end else if (i_clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign o_sync = st_r.sync;
endmodule : xpd_sync

// ===== core/xpd_regmem.sv
/*
 * Small byte memory holding the plain read/write receive settings.
 * Assumes the owner loads defaults after reset; read data is registered.
 */
`timescale 1ns/1ps
module xpd_regmem #(
    parameter int AW = 5,
    parameter int DW = 8
) (
    input  wire logic          i_clock,
    input  wire logic          i_sys_rst,
    input  wire logic          i_clk_en,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [DW-1:0] i_wdata,
    input  wire logic [AW-1:0] i_raddr,
    output logic      [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] rdata_r;

    always_ff @(posedge i_clock) begin
        if (i_clk_en && i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            rdata_r <= '0;
        end else if (i_clk_en) begin
            rdata_r <= mem[i_raddr];
        end
    end

    assign o_rdata = rdata_r;
endmodule : xpd_regmem

// ===== core/xpd_regbank.sv
/*
 * Power-down control and receive register bank of a serial transceiver.
 * Holds path sleep bits, wake-up on access, deferred writes,
 * full-recalibration requests and the sticky receive alarm status.
 * Assumes the serial port front end runs on i_clock and presents one
 * access at a time; live alarms and the port-select pin are asynchronous.
 */
`timescale 1ns/1ps
module xpd_regbank #(
    parameter logic [7:0] ID_LOW = 8'h5a,   // Arbitrary identity value
    parameter logic [7:0] ID_REV = 8'h01    // Arbitrary identity value
) (
    input  wire logic              i_clock,
    input  wire logic              i_sys_rst,
    input  wire logic              i_clk_en,
    input  wire logic              i_host_port_select,
    input  wire xpd_pkg::xpd_acc_t i_acc,
    output logic                   o_acc_ready,
    output logic                   o_acc_ack,
    output logic       [7:0]       o_acc_rdata,
    input  wire xpd_pkg::xpd_live_t i_rx_live,
    output xpd_pkg::xpd_ctl_t      o_ctl,
    output logic       [7:0]       o_chip_cfg,
    output logic                   o_int_n
);
    import xpd_pkg::*;

    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_IDLE = 2'b01,
        ST_READ = 2'b11
    } xpd_fsm_t;

    typedef struct packed {
        xpd_fsm_t          fsm;
        logic [MEM_AW-1:0] init_addr;
        logic              rx_sleep;
        logic              tx_sleep;
        logic              last_tx;
        logic [7:0]        chip_cfg;
        logic [6:0]        mask;
        logic [6:0]        stat;
        logic [3:0]        rx_cal;
        logic [7:1]        tx_cfg;
        logic [7:0]        tx_cal;
        logic [TICK_W-1:0] tick;
        logic              por_recal;
        logic              rx_pend;
        logic              rx_recal;
        logic              tx_recal;
        logic              rx_load;
        logic              ack;
        logic [7:0]        rd_addr;
        logic              rd_blank;
        logic [7:0]        rdata;
    } xpd_st_t;

    xpd_st_t            st_r;
    xpd_st_t            st_nxt;
    logic               mem_we;
    logic [MEM_AW-1:0]  mem_waddr;
    logic [7:0]         mem_wdata;
    logic [MEM_AW-1:0]  mem_raddr;
    logic [7:0]         mem_q;
    xpd_live_t          live_s;
    logic               spi_sel_s;

    // Port select pin and analog alarms cross in through two flops
    xpd_sync #(
        .WIDTH($bits(xpd_live_t) + 1)
    ) u_sync (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_clk_en  (i_clk_en),
        .i_async   ({i_host_port_select, i_rx_live}),
        .o_sync    ({spi_sel_s, live_s})
    );

    xpd_regmem #(
        .AW(MEM_AW),
        .DW(8)
    ) u_mem (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_clk_en  (i_clk_en),
        .i_we      (mem_we),
        .i_waddr   (mem_waddr),
        .i_wdata   (mem_wdata),
        .i_raddr   (mem_raddr),
        .o_rdata   (mem_q)
    );

    // Receive-side addresses other than the always-visible ones
    function automatic logic is_rx_reg(input logic [7:0] a);
        is_rx_reg = (a >= ADDR_RX_INT_MASK) && (a <= ADDR_TP_SEL);
    endfunction : is_rx_reg

    function automatic logic [7:0] read_mux(input xpd_st_t s,
                                            input xpd_live_t lv,
                                            input logic [7:0] q);
        logic [7:0] a;
        a        = s.rd_addr;
        read_mux = 8'h00;
        if (s.rd_blank) begin
            read_mux = 8'h00;
        end else if (is_rx_reg(a) && s.rx_sleep) begin
            read_mux = 8'h00;
        end else if (is_mem_reg(a)) begin
            read_mux = q;
        end else begin
            case (a)
                ADDR_ID_LOW:      read_mux = ID_LOW;
                ADDR_ID_REV:      read_mux = ID_REV;
                ADDR_CHIP_CFG:    read_mux = s.chip_cfg;
                ADDR_RX_POWER:    read_mux = {7'h00, s.rx_sleep};
                ADDR_RX_INT_MASK: read_mux = {1'b0, s.mask};
                ADDR_RX_INT_STAT: read_mux = {1'b0, s.stat};
                ADDR_RX_CAL:      read_mux = {4'h0, s.rx_cal};
                ADDR_RX_ALARM:    read_mux = {1'b0, lv.alarm};
                ADDR_RX_LOSS_ST:  read_mux = lv.loss;
                ADDR_PEAK_LOW:    read_mux = lv.peak[7:0];
                ADDR_PEAK_HIGH:   read_mux = {6'h00, lv.peak[9:8]};
                ADDR_SQM_VALUE:   read_mux = {2'b00, lv.sqm};
                ADDR_TX_POWER:    read_mux = {s.tx_cfg, s.tx_sleep};
                ADDR_TX_CAL:      read_mux = s.tx_sleep ? 8'h00 : s.tx_cal;
                default:          read_mux = 8'h00;
            endcase
        end
    endfunction : read_mux

    always_comb begin
        logic       both_down;
        logic       wake;
        logic       do_acc;
        logic [6:0] clr;
        logic [6:0] set;
        both_down = 1'b0;
        wake      = 1'b0;
        do_acc    = 1'b0;
        clr       = 7'h00;
        set       = 7'h00;

        st_nxt          = st_r;
        st_nxt.ack      = 1'b0;
        st_nxt.rx_recal = 1'b0;
        st_nxt.tx_recal = 1'b0;
        st_nxt.rx_load  = 1'b0;
        mem_we          = 1'b0;
        mem_waddr       = i_acc.addr[MEM_AW-1:0];
        mem_wdata       = i_acc.wdata;
        mem_raddr       = i_acc.addr[MEM_AW-1:0];

        // Alarm sampling tick
        if (st_r.tick == TICK_LAST) begin
            st_nxt.tick = '0;
            set         = live_s.alarm & ~st_r.mask;
        end else begin
            st_nxt.tick = st_r.tick + 1'b1;
        end

        both_down = st_r.rx_sleep && st_r.tx_sleep;

        case (st_r.fsm)
            ST_INIT: begin
                mem_we         = 1'b1;
                mem_waddr      = st_r.init_addr;
                mem_wdata      = mem_default(st_r.init_addr);
                st_nxt.init_addr = st_r.init_addr + 1'b1;
                if (st_r.init_addr == MEM_LAST) begin
                    st_nxt.fsm = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (i_acc.valid) begin
                    st_nxt.rd_addr  = i_acc.addr;
                    st_nxt.rd_blank = both_down;
                    if (both_down) begin
                        wake = spi_sel_s;
                    end else begin
                        do_acc = i_acc.write;
                    end
                    if (i_acc.write) begin
                        st_nxt.ack = 1'b1;
                    end else begin
                        st_nxt.fsm = ST_READ;
                    end
                end
            end
            ST_READ: begin
                st_nxt.rdata = read_mux(st_r, live_s, mem_q);
                st_nxt.ack   = 1'b1;
                st_nxt.fsm   = ST_IDLE;
            end
            default: begin
                st_nxt.fsm = ST_IDLE;
            end
        endcase

        // Only the path that went to sleep last comes back
        if (wake) begin
            if (st_r.last_tx) begin
                st_nxt.tx_sleep = 1'b0;
            end else begin
                st_nxt.rx_sleep = 1'b0;
            end
        end

        if (do_acc) begin
            case (i_acc.addr)
                ADDR_CHIP_CFG: st_nxt.chip_cfg = i_acc.wdata;
                ADDR_RX_POWER: begin
                    st_nxt.rx_sleep = i_acc.wdata[BIT_SLEEP];
                    if (i_acc.wdata[BIT_SLEEP] && !st_r.rx_sleep) begin
                        st_nxt.last_tx = 1'b0;
                    end
                end
                ADDR_RX_INT_MASK: st_nxt.mask = i_acc.wdata[6:0];
                ADDR_RX_INT_STAT: clr = ~i_acc.wdata[6:0];
                ADDR_RX_CAL: st_nxt.rx_cal = i_acc.wdata[3:0];
                ADDR_TX_POWER: begin
                    st_nxt.tx_cfg   = i_acc.wdata[7:1];
                    st_nxt.tx_sleep = i_acc.wdata[BIT_SLEEP];
                    if (i_acc.wdata[BIT_SLEEP] && !st_r.tx_sleep) begin
                        st_nxt.last_tx = 1'b1;
                    end
                end
                ADDR_TX_CAL: st_nxt.tx_cal = i_acc.wdata;
                default: begin
                    if (is_mem_reg(i_acc.addr)) begin
                        mem_we = 1'b1;
                        if (st_r.rx_sleep) begin
                            st_nxt.rx_pend = 1'b1;
                        end else begin
                            st_nxt.rx_load = 1'b1;
                        end
                    end
                end
            endcase
        end

        // Recalibration waits while its path sleeps, then fires once
        if ((st_r.rx_cal[BIT_FULL_RECAL] || st_r.por_recal) && !st_r.rx_sleep
            && !(do_acc && i_acc.addr == ADDR_RX_CAL)) begin
            st_nxt.rx_recal                 = 1'b1;
            st_nxt.rx_cal[BIT_FULL_RECAL]   = 1'b0;
            st_nxt.rx_load                  = st_nxt.rx_load | st_r.rx_pend;
            st_nxt.rx_pend                  = 1'b0;
        end
        if ((st_r.tx_cal[BIT_FULL_RECAL] || st_r.por_recal) && !st_r.tx_sleep
            && !(do_acc && i_acc.addr == ADDR_TX_CAL)) begin
            st_nxt.tx_recal               = 1'b1;
            st_nxt.tx_cal[BIT_FULL_RECAL] = 1'b0;
        end
        st_nxt.por_recal = 1'b0;

        // Sampled alarms win over a clear in the same cycle
        st_nxt.stat = (st_r.stat & ~clr) | set;
        if (!st_r.chip_cfg[BIT_GLOBAL_IE]) begin
            st_nxt.stat = 7'h00;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            st_r           <= '0;
            st_r.fsm       <= ST_INIT;
            st_r.chip_cfg  <= RST_CHIP_CFG;
            st_r.tx_cfg    <= RST_TX_POWER[7:1];
            st_r.tx_sleep  <= RST_TX_POWER[BIT_SLEEP];
            st_r.tx_cal    <= RST_TX_CAL;
            st_r.por_recal <= 1'b1;
        end else if (i_clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign o_acc_ready     = (st_r.fsm == ST_IDLE);
    assign o_acc_ack       = st_r.ack;
    assign o_acc_rdata     = st_r.rdata;
    assign o_ctl.rx_sleep  = st_r.rx_sleep;
    assign o_ctl.tx_sleep  = st_r.tx_sleep;
    assign o_ctl.rx_recal  = st_r.rx_recal;
    assign o_ctl.tx_recal  = st_r.tx_recal;
    assign o_ctl.rx_load   = st_r.rx_load;
    assign o_chip_cfg      = st_r.chip_cfg;
    assign o_int_n         = ~|st_r.stat;
endmodule : xpd_regbank

// ===== dv/xpd_chk.sv
/* Checker for xpd_regbank: access, sleep, wake and recalibration timing.
   Assumes it is bound to the top module with clock enable held high. */
`timescale 1ns/1ps
module xpd_chk (
    input wire logic              i_clock,
    input wire logic              i_sys_rst,
    input wire logic              i_host_port_select,
    input wire xpd_pkg::xpd_acc_t i_acc,
    input wire logic              o_acc_ready,
    input wire logic              o_acc_ack,
    input wire xpd_pkg::xpd_ctl_t o_ctl,
    input wire logic [7:0]        o_chip_cfg,
    input wire logic              o_int_n
);
    import xpd_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    logic tk;
    logic both;
    assign tk   = o_acc_ready && i_acc.valid;
    assign both = o_ctl.rx_sleep && o_ctl.tx_sleep;
    sequence s_rd;
        tk && !i_acc.write;
    endsequence
    sequence s_wr(a);
        tk && i_acc.write && !both && i_acc.addr == a;
    endsequence
    a_write_ack: assert property (
        tk && i_acc.write |=> o_acc_ack) else $error("write not acked");
    a_read_answer: assert property (
        s_rd |=> !o_acc_ready && !o_acc_ack ##1 o_acc_ack) else $error("read answer late");
    a_rx_sleep_bit: assert property (
        s_wr(ADDR_RX_POWER) |=> o_ctl.rx_sleep == $past(i_acc.wdata[0]))
        else $error("rx sleep not applied");
    a_tx_sleep_bit: assert property (
        s_wr(ADDR_TX_POWER) |=> o_ctl.tx_sleep == $past(i_acc.wdata[0]))
        else $error("tx sleep not applied");
    a_rx_recal_go: assert property (
        s_wr(ADDR_RX_CAL) ##0 i_acc.wdata[3] && !o_ctl.rx_sleep |-> ##2 o_ctl.rx_recal)
        else $error("rx recal missing");
    a_held_asleep: assert property (
        o_ctl.rx_sleep |-> !o_ctl.rx_recal && !o_ctl.rx_load) else $error("rx acted asleep");
    a_two_wire: assert property (
        (!i_host_port_select) [*3] ##0 both |=> both) else $error("two-wire woke");
    a_spi_wake: assert property (
        i_host_port_select [*3] ##0 both && tk |-> ##[1:2] (o_ctl.rx_sleep ^ o_ctl.tx_sleep))
        else $error("wake not single path");
    a_ie_off: assert property (
        !o_chip_cfg[BIT_GLOBAL_IE] && !$past(o_chip_cfg[BIT_GLOBAL_IE])
        && !$past(o_chip_cfg[BIT_GLOBAL_IE], 2) |-> o_int_n) else $error("int while disabled");
    a_auto_recal: assert property (
        $fell(i_sys_rst) |-> ##[0:1] (o_ctl.rx_recal && o_ctl.tx_recal))
        else $error("no recal after reset");
endmodule : xpd_chk

bind xpd_regbank xpd_chk u_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_host_port_select(i_host_port_select), .i_acc(i_acc), .o_acc_ready(o_acc_ready),
    .o_acc_ack(o_acc_ack), .o_ctl(o_ctl), .o_chip_cfg(o_chip_cfg), .o_int_n(o_int_n));

// ===== dv/xpd_host.sv
/* Host model: issues one register access at a time and returns the answer.
   Assumes the bench calls acc and nothing else drives the access port. */
`timescale 1ns/1ps
module xpd_host (
    input  wire logic        i_clock,
    input  wire logic        i_ready,
    input  wire logic        i_ack,
    input  wire logic [7:0]  i_rdata,
    output xpd_pkg::xpd_acc_t o_acc
);
    import xpd_pkg::*;
    initial o_acc = '0;
    task automatic acc(input logic w, input logic [7:0] a, d,
                       output logic [7:0] q, output bit ok);
        int n;
        ok = 0;
        q = 8'h00;
        @(negedge i_clock);
        o_acc = {1'b1, w, a, d};
        for (n = 0; n < 100 && i_ready !== 1'b1; n++) @(negedge i_clock);
        if (i_ready === 1'b1) begin
            @(negedge i_clock);
            // Released lines show the inverse of the last value
            o_acc = {1'b0, ~w, ~a, ~d};
            for (n = 0; n < 8 && !ok; n++) begin
                if (i_ack === 1'b1) begin
                    ok = 1;
                    q = i_rdata;
                end else @(negedge i_clock);
            end
        end
    endtask : acc
endmodule : xpd_host

// ===== dv/xpd_regbank_bench.sv
/* Bench for xpd_regbank: the host model drives accesses, the bench drives
   pins and live alarms and judges results. Assumes clock enable high. */
`timescale 1ns/1ps
module xpd_regbank_bench;
    import xpd_pkg::*;
    localparam logic [7:0] ID_A = 8'h3c;  // Arbitrary identity value
    localparam logic [7:0] ID_B = 8'h07;  // Arbitrary identity value
    logic      clk, rst, sel, rdy, ack, int_n;
    logic [7:0] rdata, cfg;
    xpd_acc_t  acc;
    xpd_live_t live;
    xpd_ctl_t  ctl;
    int        n_fail = 0, compares = 0, n_rxr = 0, n_txr = 0, n_ld = 0;
    xpd_regbank #(.ID_LOW(ID_A), .ID_REV(ID_B)) DUT (.i_clock(clk), .i_sys_rst(rst),
        .i_clk_en(1'b1), .i_host_port_select(sel), .i_acc(acc), .o_acc_ready(rdy),
        .o_acc_ack(ack), .o_acc_rdata(rdata), .i_rx_live(live), .o_ctl(ctl),
        .o_chip_cfg(cfg), .o_int_n(int_n));
    xpd_host host (.i_clock(clk), .i_ready(rdy), .i_ack(ack), .i_rdata(rdata), .o_acc(acc));
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        n_rxr += int'(ctl.rx_recal === 1'b1);
        n_txr += int'(ctl.tx_recal === 1'b1);
        n_ld += int'(ctl.rx_load === 1'b1);
    end
    task automatic chk(input string nm, input logic [7:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic xs(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        bit ok;
        host.acc(w, a, d, q, ok);
        if (!ok) begin
            n_fail++;
            $display("[ERR] ack_%h exp 1 got 0", a);
            stop_test();
        end
    endtask : xs
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        xs(1'b1, a, d, q);
    endtask : wr
    task automatic rc(input string nm, input logic [7:0] a, exp);
        logic [7:0] q;
        xs(1'b0, a, 8'h00, q);
        chk(nm, q, exp);
    endtask : rc
    function automatic logic [7:0] slp();
        return {6'h00, ctl.rx_sleep, ctl.tx_sleep};
    endfunction : slp
    task automatic do_reset();
        rst = 1;
        repeat (8) @(negedge clk);
        rst = 0;
    endtask : do_reset
    task automatic t_regs();
        logic [15:0] tb [22] = '{16'h0258, 16'h0300, 16'h0400, 16'h0500, 16'h0640,
            16'h0715, 16'h0800, 16'h0a01, 16'h0c0f, 16'h0d70, 16'h1105, 16'h1260,
            16'h1411, 16'h1500, 16'h1a29, 16'h1b0f, 16'h1c02, 16'h1d00, 16'h8322,
            16'h8800, 16'h0e00, 16'h1700};
        foreach (tb[i]) rc("reset_val", tb[i][15:8], tb[i][7:0]);
        rc("id_low", ADDR_ID_LOW, ID_A);
        rc("id_rev", ADDR_ID_REV, ID_B);
        chk("sleep_rst", slp(), 8'h00);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_rw();
        wr(ADDR_TP_SEL, 8'ha5);
        rc("rw", ADDR_TP_SEL, 8'ha5);
        wr(ADDR_RX_ALARM, 8'hff);
        rc("ro", ADDR_RX_ALARM, 8'h00);
        wr(8'h0e, 8'h55);
        rc("unmapped", 8'h0e, 8'h00);
        rc("peak_lo", ADDR_PEAK_LOW, 8'hb5);
        rc("peak_hi", ADDR_PEAK_HIGH, 8'h02);
        $display("t_rw done");
    endtask : t_rw
    task automatic t_defer();
        int a, b;
        wr(ADDR_RX_POWER, 8'h01);
        chk("rx_sleep", slp(), 8'h02);
        rc("cfg_live", ADDR_CHIP_CFG, 8'h58);
        a = n_rxr;
        b = n_ld;
        wr(ADDR_RX_MULT, 8'h4c);
        wr(ADDR_RX_CAL, 8'h08);
        repeat (6) @(negedge clk);
        chk("held", 8'(n_rxr - a + n_ld - b), 8'h00);
        wr(ADDR_RX_POWER, 8'h00);
        repeat (6) @(negedge clk);
        chk("rx_recal", 8'(n_rxr - a), 8'h01);
        chk("load", {7'h00, n_ld > b}, 8'h01);
        rc("stored", ADDR_RX_MULT, 8'h4c);
        a = n_txr;
        wr(ADDR_TX_CAL, 8'h08);
        repeat (4) @(negedge clk);
        chk("tx_recal", 8'(n_txr - a), 8'h01);
        $display("t_defer done");
    endtask : t_defer
    task automatic t_spi();
        wr(ADDR_TX_POWER, 8'h23);
        wr(ADDR_RX_POWER, 8'h01);
        rc("asleep_rd", ADDR_CHIP_CFG, 8'h00);
        chk("woke_rx", slp(), 8'h01);
        rc("rx_bit", ADDR_RX_POWER, 8'h00);
        wr(ADDR_TX_POWER, 8'h22);
        wr(ADDR_TX_CAL, 8'h08);
        wr(ADDR_RX_POWER, 8'h01);
        wr(ADDR_TX_POWER, 8'h23);
        wr(ADDR_TP_SEL, 8'h00);
        chk("woke_tx", slp(), 8'h02);
        wr(ADDR_RX_POWER, 8'h00);
        wr(ADDR_RX_CAL, 8'h08);
        chk("all_up", slp(), 8'h00);
        $display("t_spi done");
    endtask : t_spi
    task automatic t_twowire();
        int a;
        sel = 0;
        wr(ADDR_TX_POWER, 8'h23);
        wr(ADDR_RX_POWER, 8'h01);
        wr(ADDR_RX_POWER, 8'h00);
        rc("no_wake", ADDR_CHIP_CFG, 8'h00);
        chk("both", slp(), 8'h03);
        a = n_rxr + n_txr;
        do_reset();
        repeat (2) @(negedge clk);
        chk("pwr_up", slp(), 8'h00);
        chk("auto_cal", 8'(n_rxr + n_txr - a), 8'h02);
        sel = 1;
        $display("t_twowire done");
    endtask : t_twowire
    task automatic t_int();
        int i;
        live.alarm = 7'h01;
        repeat (30) @(negedge clk);
        chk("ie_off", {7'h00, int_n}, 8'h01);
        rc("ie_off_st", ADDR_RX_INT_STAT, 8'h00);
        wr(ADDR_CHIP_CFG, 8'h78);
        chk("cfg", cfg, 8'h78);
        for (i = 0; i < 40 && int_n !== 1'b0; i++) @(negedge clk);
        chk("int", {7'h00, int_n}, 8'h00);
        rc("sticky", ADDR_RX_INT_STAT, 8'h01);
        wr(ADDR_RX_INT_MASK, 8'h01);
        wr(ADDR_RX_INT_STAT, 8'h00);
        repeat (30) @(negedge clk);
        chk("masked", {7'h00, int_n}, 8'h01);
        live.alarm = 7'h00;
        $display("t_int done");
    endtask : t_int
    initial begin
        rst = 1;
        sel = 1;
        live = '0;
        live.peak = 10'h2b5;
        do_reset();
        t_regs();
        t_rw();
        t_defer();
        t_spi();
        t_twowire();
        t_int();
        stop_test();
    end
endmodule : xpd_regbank_bench
